// ===== src/bpu_pkg.sv
package bpu_pkg;
   localparam int ADDR_W = 32;
   localparam int BTT_IDX_W = 6;
   localparam int BTT_ENTRIES = 64;
   localparam int BTT_TAG_W = ADDR_W - BTT_IDX_W - 2;
   localparam int RAS_DEPTH = 16;
   localparam int RAS_PTR_W = 4;
   localparam logic [RAS_PTR_W:0] RAS_CNT_RESET = 5'h00;
   localparam logic [RAS_PTR_W-1:0] RAS_TOP_RESET = 4'h0;
   localparam logic [1:0] CTR_WEAK_TAKEN = 2'h2;
   localparam logic [ADDR_W-1:0] INSN_STEP = 32'h00000004;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h00000000;

   typedef enum logic [2:0] {
      BPU_COND,
      BPU_CALL,
      BPU_RET,
      BPU_INDIRECT,
      BPU_FAR,
      BPU_NONE
   } bpu_kind_type;

   typedef enum {
      BPU_SRC_NONE,
      BPU_SRC_TABLE,
      BPU_SRC_STATIC,
      BPU_SRC_STACK
   } bpu_src_type;
endpackage

// ===== src/bpu_ras.sv
`timescale 1ns/1ps
`default_nettype none
module bpu_ras
   import bpu_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // stack operations
   input wire logic push,
   input wire logic [ADDR_W-1:0] push_addr,
   input wire logic pop,
   // checkpoint restore
   input wire logic restore,
   input wire logic [RAS_PTR_W-1:0] restore_top,
   input wire logic [RAS_PTR_W:0] restore_cnt,
   // state
   output logic [ADDR_W-1:0] top_addr,
   output logic top_valid,
   output logic [RAS_PTR_W-1:0] top_ptr,
   output logic [RAS_PTR_W:0] count
);
   logic [ADDR_W-1:0] stack_mem [RAS_DEPTH];
   logic [RAS_PTR_W-1:0] next_top;

   assign top_addr = stack_mem[top_ptr];
   assign top_valid = (count != RAS_CNT_RESET);
   assign next_top = top_ptr + 4'h1;

   // circular storage: a push when full silently drops the oldest entry
   always_ff @(posedge clk_sys) begin
      if (push && !restore) begin
         stack_mem[next_top] <= push_addr;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         top_ptr <= RAS_TOP_RESET;
         count <= RAS_CNT_RESET;
      end else if (restore) begin
         top_ptr <= restore_top;
         count <= restore_cnt;
      end else if (push) begin
         top_ptr <= next_top;
         if (count != 5'h10) begin
            count <= count + 5'h01;
         end
      end else if (pop && top_valid) begin
         top_ptr <= top_ptr - 4'h1;
         count <= count - 5'h01;
      end
   end
endmodule
`default_nettype wire

// ===== src/bpu_top.sv
`timescale 1ns/1ps
`default_nettype none
module bpu_top
   import bpu_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // fetch stage lookup
   input wire logic fetch_valid,
   input wire logic [ADDR_W-1:0] fetch_addr,
   // decode stage
   input wire logic dec_valid,
   input wire logic [ADDR_W-1:0] dec_addr,
   input wire logic [2:0] dec_kind,
   input wire logic [ADDR_W-1:0] dec_disp,
   // retirement update
   input wire logic ret_valid,
   input wire logic [ADDR_W-1:0] ret_addr,
   input wire logic [ADDR_W-1:0] ret_target,
   input wire logic ret_taken,
   input wire logic [2:0] ret_kind,
   // execution misprediction
   input wire logic mis_valid,
   input wire logic [ADDR_W-1:0] mis_target,
   input wire logic [RAS_PTR_W-1:0] mis_ras_top,
   input wire logic [RAS_PTR_W:0] mis_ras_cnt,
   // fetch-stage prediction
   output logic fpred_valid,
   output logic fpred_taken,
   output logic [ADDR_W-1:0] fpred_target,
   // decode-stage prediction
   output logic dpred_valid,
   output logic dpred_taken,
   output logic [ADDR_W-1:0] dpred_target,
   output logic dpred_static,
   output logic [RAS_PTR_W-1:0] dpred_ras_top,
   output logic [RAS_PTR_W:0] dpred_ras_cnt,
   // trace build and redirect
   output logic trace_follow,
   output logic redirect_valid,
   output logic [ADDR_W-1:0] redirect_addr,
   output logic flush_young
);
   logic [ADDR_W-1:0] btt_target [BTT_ENTRIES];
   logic [BTT_TAG_W-1:0] btt_tag [BTT_ENTRIES];
   logic [1:0] btt_ctr [BTT_ENTRIES];
   logic [BTT_ENTRIES-1:0] btt_valid;
   logic [ADDR_W-1:0] ras_top_addr;
   logic ras_top_valid;
   logic [RAS_PTR_W-1:0] ras_top_ptr;
   logic [RAS_PTR_W:0] ras_count;
   logic dec_near;
   logic dec_hit;
   logic ras_push;
   logic ras_pop;
   bpu_kind_type kind_d;
   bpu_src_type next_src;
   logic next_taken;
   logic next_pvalid;
   logic [ADDR_W-1:0] next_target;
   logic [BTT_IDX_W-1:0] f_idx;
   logic [BTT_IDX_W-1:0] d_idx;
   logic [BTT_IDX_W-1:0] r_idx;

   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   function automatic logic [BTT_IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[BTT_IDX_W+1:2];
   endfunction

   function automatic logic [BTT_TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:BTT_IDX_W+2];
   endfunction

   function automatic logic is_near(input logic [2:0] k);
      return k == BPU_COND || k == BPU_CALL || k == BPU_RET
         || k == BPU_INDIRECT;
   endfunction

   assign f_idx = idx_of(fetch_addr);
   assign d_idx = idx_of(dec_addr);
   assign r_idx = idx_of(ret_addr);
   assign kind_d = bpu_kind_type'(dec_kind);
   assign dec_near = dec_valid && is_near(dec_kind);
   assign dec_hit = btt_valid[d_idx] && btt_tag[d_idx] == tag_of(dec_addr);
   // a mispredict squashes the decode slot, so its stack ops never land
   assign ras_push = dec_near && kind_d == BPU_CALL && !mis_valid;
   assign ras_pop = dec_near && kind_d == BPU_RET && !mis_valid;

   bpu_ras bpu_ras_inst (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .push(ras_push),
      .push_addr(dec_addr + INSN_STEP),
      .pop(ras_pop),
      .restore(mis_valid),
      .restore_top(mis_ras_top),
      .restore_cnt(mis_ras_cnt),
      .top_addr(ras_top_addr),
      .top_valid(ras_top_valid),
      .top_ptr(ras_top_ptr),
      .count(ras_count)
   );

   // table written only by retirement, never speculatively
   always_ff @(posedge clk_sys) begin
      if (ret_valid && is_near(ret_kind) && ret_kind != BPU_RET) begin
         btt_target[r_idx] <= ret_target;
         btt_tag[r_idx] <= tag_of(ret_addr);
         if (btt_valid[r_idx] && btt_tag[r_idx] == tag_of(ret_addr)) begin
            if (ret_taken && btt_ctr[r_idx] != 2'h3) begin
               btt_ctr[r_idx] <= btt_ctr[r_idx] + 2'h1;
            end else if (!ret_taken && btt_ctr[r_idx] != 2'h0) begin
               btt_ctr[r_idx] <= btt_ctr[r_idx] - 2'h1;
            end
         end else begin
            btt_ctr[r_idx] <= ret_taken ? CTR_WEAK_TAKEN : 2'h1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         btt_valid <= '0;
      end else if (ret_valid && is_near(ret_kind) && ret_kind != BPU_RET) begin
         btt_valid[r_idx] <= 1'b1;
      end
   end

   // fetch lookup registered; answer the cycle after the address
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fpred_valid <= 1'b0;
         fpred_taken <= 1'b0;
         fpred_target <= ADDR_RESET;
      end else begin
         fpred_valid <= fetch_valid && btt_valid[f_idx]
            && btt_tag[f_idx] == tag_of(fetch_addr) && !mis_valid;
         fpred_taken <= btt_ctr[f_idx][1];
         fpred_target <= btt_target[f_idx];
      end
   end

   always_comb begin
      next_src = BPU_SRC_NONE;
      next_taken = 1'b0;
      next_pvalid = 1'b0;
      next_target = dec_addr + INSN_STEP;
      if (dec_near) begin
         if (kind_d == BPU_RET) begin
            next_taken = 1'b1;
            next_pvalid = ras_top_valid;
            next_src = ras_top_valid ? BPU_SRC_STACK : BPU_SRC_NONE;
            next_target = ras_top_addr;
         end else if (dec_hit) begin
            next_src = BPU_SRC_TABLE;
            next_pvalid = 1'b1;
            next_taken = btt_ctr[d_idx][1];
            next_target = btt_target[d_idx];
         end else if (kind_d == BPU_COND || kind_d == BPU_CALL) begin
            next_src = BPU_SRC_STATIC;
            next_pvalid = 1'b1;
            next_taken = dec_disp[ADDR_W-1];
            next_target = dec_addr + dec_disp;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dpred_valid <= 1'b0;
         dpred_taken <= 1'b0;
         dpred_target <= ADDR_RESET;
         dpred_static <= 1'b0;
         dpred_ras_top <= RAS_TOP_RESET;
         dpred_ras_cnt <= RAS_CNT_RESET;
         trace_follow <= 1'b0;
      end else begin
         dpred_valid <= next_pvalid && !mis_valid;
         dpred_taken <= next_taken;
         dpred_target <= next_target;
         dpred_static <= next_src == BPU_SRC_STATIC;
         dpred_ras_top <= ras_top_ptr;
         dpred_ras_cnt <= ras_count;
         trace_follow <= next_pvalid && next_taken && !mis_valid;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         redirect_valid <= 1'b0;
         redirect_addr <= ADDR_RESET;
         flush_young <= 1'b0;
      end else begin
         redirect_valid <= mis_valid;
         redirect_addr <= mis_target;
         flush_young <= mis_valid;
      end
   end

   a_ret_taken: assert property (
      dec_valid && dec_kind == BPU_RET && ras_top_valid && !mis_valid
      |=> dpred_valid && dpred_taken)
      else $error("return not predicted taken");
   a_far_none: assert property (
      dec_valid && dec_kind == BPU_FAR |=> !dpred_valid)
      else $error("far transfer predicted");
   a_static_dir: assert property (
      dec_near && !dec_hit && dec_kind == BPU_COND && !mis_valid
      |=> dpred_static && dpred_taken == $past(dec_disp[ADDR_W-1]))
      else $error("static direction wrong");
   a_static_miss: assert property (
      dec_valid && dec_hit |=> !dpred_static)
      else $error("static used on table hit");
   a_redirect: assert property (
      mis_valid |=> redirect_valid && flush_young
      && redirect_addr == $past(mis_target))
      else $error("redirect missing");
   a_ras_restore: assert property (
      mis_valid |=> ras_top_ptr == $past(mis_ras_top)
      && ras_count == $past(mis_ras_cnt))
      else $error("stack not restored");
   a_ras_empty: assert property (
      dec_valid && dec_kind == BPU_RET && !ras_top_valid
      |=> !dpred_valid)
      else $error("empty stack predicted");
   a_btt_learn: assert property (
      ret_valid && ret_kind == BPU_COND && !mis_valid
      ##1 fetch_valid && fetch_addr == $past(ret_addr) && !mis_valid
      |=> fpred_valid && fpred_target == $past(ret_target, 2))
      else $error("retired target not learned");
   a_ras_push: assert property (
      ras_push |=> ras_top_addr == $past(dec_addr) + INSN_STEP)
      else $error("call not pushed");

   c_table_hit: cover property (fpred_valid && fpred_taken);
   c_static: cover property (dpred_static && dpred_taken);
   c_stack_ret: cover property (ras_push ##[1:8] ras_pop);
   c_mispredict: cover property (redirect_valid);
endmodule
`default_nettype wire

// ===== verification/bpu_retire_model.sv
`timescale 1ns/1ps
`default_nettype none
// retirement side: one update pulse per retired branch
module bpu_retire_model
   import bpu_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // update towards the predictor
   output var logic ret_valid,
   output var logic [ADDR_W-1:0] ret_addr,
   output var logic [ADDR_W-1:0] ret_target,
   output var logic ret_taken,
   output var logic [2:0] ret_kind
);
   initial begin
      ret_valid = 1'b0;
      ret_addr = 32'h00000000;
      ret_target = 32'h00000000;
      ret_taken = 1'b0;
      ret_kind = 3'h5;
   end

   // address and resolved target travel together with the strobe
   task automatic retire(input logic [ADDR_W-1:0] a,
                         input logic [ADDR_W-1:0] t,
                         input logic tk, input logic [2:0] k);
      @(negedge clk_sys);
      ret_valid = 1'b1;
      ret_addr = a;
      ret_target = t;
      ret_taken = tk;
      ret_kind = k;
      @(negedge clk_sys);
      // stale address, target and direction flip so a design reading them off-strobe is caught
      ret_valid = 1'b0;
      ret_addr = ~ret_addr;
      ret_target = ~ret_target;
      ret_taken = ~ret_taken;
   endtask
endmodule
`default_nettype wire

// ===== verification/bpu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bpu_top_tb;
   import bpu_pkg::*;
   logic clk_sys, rst_n, fetch_valid, dec_valid, mis_valid;
   logic [31:0] fetch_addr, dec_addr, dec_disp, mis_target;
   logic [2:0] dec_kind;
   logic [3:0] mis_ras_top, dpred_ras_top, ck_top;
   logic [4:0] mis_ras_cnt, dpred_ras_cnt, ck_cnt;
   logic ret_valid, ret_taken, fpred_valid, fpred_taken, dpred_valid;
   logic dpred_taken, dpred_static, trace_follow, redirect_valid, flush_young;
   logic [31:0] ret_addr, ret_target, fpred_target, dpred_target;
   logic [31:0] redirect_addr;
   logic [2:0] ret_kind;
   logic dv, dt, ds, tf, fv, ft;
   logic [31:0] dtg, ftg;
   int fails = 0;
   int num_checks = 0;

   bpu_retire_model bpu_retire_model_inst (.clk_sys(clk_sys),
      .ret_valid(ret_valid), .ret_addr(ret_addr), .ret_target(ret_target),
      .ret_taken(ret_taken), .ret_kind(ret_kind));

   bpu_top bpu_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .dec_valid(dec_valid), .dec_addr(dec_addr), .dec_kind(dec_kind),
      .dec_disp(dec_disp), .ret_valid(ret_valid), .ret_addr(ret_addr),
      .ret_target(ret_target), .ret_taken(ret_taken), .ret_kind(ret_kind),
      .mis_valid(mis_valid), .mis_target(mis_target),
      .mis_ras_top(mis_ras_top), .mis_ras_cnt(mis_ras_cnt),
      .fpred_valid(fpred_valid), .fpred_taken(fpred_taken),
      .fpred_target(fpred_target), .dpred_valid(dpred_valid),
      .dpred_taken(dpred_taken), .dpred_target(dpred_target),
      .dpred_static(dpred_static), .dpred_ras_top(dpred_ras_top),
      .dpred_ras_cnt(dpred_ras_cnt), .trace_follow(trace_follow),
      .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
      .flush_young(flush_young));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, e, g);
      end
   endtask

   // decode lasts two cycles so every request is followed by an idle one
   task automatic dec(input logic [2:0] k, input logic [31:0] a,
                      input logic [31:0] d);
      dec_valid = 1'b1;
      dec_kind = k;
      dec_addr = a;
      dec_disp = d;
      @(negedge clk_sys);
      {dv, dt, dtg} = {dpred_valid, dpred_taken, dpred_target};
      {ds, tf} = {dpred_static, trace_follow};
      {ck_top, ck_cnt} = {dpred_ras_top, dpred_ras_cnt};
      dec_valid = 1'b0;
      dec_addr = ~a;
      @(negedge clk_sys);
   endtask

   task automatic fetch(input logic [31:0] a);
      fetch_valid = 1'b1;
      fetch_addr = a;
      @(negedge clk_sys);
      {fv, ft, ftg} = {fpred_valid, fpred_taken, fpred_target};
      fetch_valid = 1'b0;
      fetch_addr = ~a;
      @(negedge clk_sys);
   endtask

   task automatic s_table();
      fetch(32'h00002040);
      chk("fetch miss valid", 1'b0, fv);
      // the lookup right after retirement must already hit
      bpu_retire_model_inst.retire(32'h00002040, 32'h00003000, 1'b1, 3'h0);
      fetch(32'h00002040);
      chk("fetch hit valid", 1'b1, fv);
      chk("fetch hit taken", 1'b1, ft);
      chk("fetch hit target", 32'h00003000, ftg);
      bpu_retire_model_inst.retire(32'h00002080, 32'h00005000, 1'b1, 3'h3);
      bpu_retire_model_inst.retire(32'h000020C0, 32'h00006000, 1'b1, 3'h2);
      fetch(32'h00002080);
      chk("indirect target", 32'h00005000, ftg);
      fetch(32'h000020C0);
      chk("return not stored", 1'b0, fv);
      dec(3'h0, 32'h00002040, 32'h00000010);
      chk("hit static", 1'b0, ds);
      chk("hit dir", 1'b1, dt);
      chk("hit target", 32'h00003000, dtg);
   endtask

   task automatic s_static();
      dec(3'h0, 32'h00004100, 32'hFFFFFFF0);
      chk("back valid", 1'b1, dv);
      chk("back static", 1'b1, ds);
      chk("back taken", 1'b1, dt);
      chk("back target", 32'h000040F0, dtg);
      chk("back trace", 1'b1, tf);
      dec(3'h0, 32'h00004200, 32'h00000010);
      chk("fwd taken", 1'b0, dt);
      chk("fwd trace", 1'b0, tf);
   endtask

   task automatic s_far();
      for (int k = 4; k < 6; k++) begin
         dec(3'(k), 32'h00004300, 32'hFFFFFFF0);
         chk("far valid", 1'b0, dv);
      end
   endtask

   // seventeen calls: the oldest is overwritten, sixteen come back
   task automatic s_stack();
      for (int i = 0; i < 17; i++) begin
         dec(3'h1, 32'h00010000 + 32'(i * 16), 32'h00000100);
      end
      for (int i = 16; i > 0; i--) begin
         dec(3'h2, 32'h00020000, 32'h00000000);
         chk("ret valid", 1'b1, dv);
         chk("ret taken", 1'b1, dt);
         chk("ret target", 32'h00010004 + 32'(i * 16), dtg);
      end
      dec(3'h2, 32'h00020000, 32'h00000000);
      chk("empty ret valid", 1'b0, dv);
   endtask

   task automatic s_mispredict();
      dec(3'h1, 32'h00030000, 32'h00000100);
      chk("checkpoint cnt", 5'h00, ck_cnt);
      // a call and a hit lookup in the mispredict cycle are both squashed
      mis_valid = 1'b1;
      mis_target = 32'h00031234;
      mis_ras_top = ck_top;
      mis_ras_cnt = ck_cnt;
      {dec_valid, dec_kind, dec_addr} = {1'b1, 3'h1, 32'h00030200};
      dec_disp = 32'hFFFFFFF0;
      fetch_valid = 1'b1;
      fetch_addr = 32'h00002040;
      @(negedge clk_sys);
      chk("squashed call", 1'b0, dpred_valid);
      chk("squashed trace", 1'b0, trace_follow);
      chk("squashed fetch", 1'b0, fpred_valid);
      chk("redirect", 1'b1, redirect_valid);
      chk("redirect addr", 32'h00031234, redirect_addr);
      chk("flush", 1'b1, flush_young);
      mis_valid = 1'b0;
      mis_target = 32'hFFFFFFFF;
      dec_valid = 1'b0;
      fetch_valid = 1'b0;
      @(negedge clk_sys);
      chk("redirect pulse", 1'b0, redirect_valid);
      chk("flush pulse", 1'b0, flush_young);
      dec(3'h2, 32'h00030100, 32'h00000000);
      chk("restored ret valid", 1'b0, dv);
      chk("restored top", mis_ras_top, ck_top);
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      {rst_n, fetch_valid, dec_valid, mis_valid} = 4'h0;
      {fetch_addr, dec_addr, dec_disp, mis_target} = '0;
      dec_kind = 3'h5;
      mis_ras_top = 4'h0;
      mis_ras_cnt = 5'h00;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      s_table();
      s_static();
      s_far();
      s_stack();
      s_mispredict();
      summarize();
   end
endmodule
`default_nettype wire
